// ---- sim/flash_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MK = 8'h00, TY = 8'h00, CP = 8'h00, DV = 8'h00, KEY = 8'h00,
  parameter logic [63:0] UID = 64'h0,
  parameter int TSE_NS = 1600
) (
  // Pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  output logic [3:0] io_in
);
  logic [7:0] mem [1:3][0:255];
  logic [3:1] lock;
  logic [3:0] q, oe;
  logic [31:0] v;
  logic [7:0] op, p;
  logic write_latch_flag, busy, pend, fz;
  int r;
  // Released lanes toggle so a stale value is never read back
  assign io_in = (io_oe & io_out) | (~io_oe & oe & q) | (~io_oe & ~oe & {4{fz}});
  always @(sck) fz = ~fz;
  initial begin
    {write_latch_flag, busy, pend, fz, lock, oe, q} = '0;
    foreach (mem[x, y]) mem[x][y] = 8'hff;
  end
  task automatic rx(input int w, input int n);
    repeat (n) begin
      @(posedge sck);
      v = (v << w) | 32'(io_in & 4'((1 << w) - 1));
    end
  endtask
  task automatic tx(input int w, input logic [7:0] b);
    for (int k = 8 - w; k >= 0; k -= w) begin
      @(negedge sck);
      oe = (w == 1) ? 4'h2 : 4'((1 << w) - 1);
      q = (w == 1) ? {2'b00, b[k], 1'b0} : 4'(b >> k);
    end
  endtask
  always @(negedge cs_n) begin : frame
    v = '0;
    if (busy) disable frame;
    rx(1, 8);
    op = v[7:0];
    case (op)
      8'h06: write_latch_flag = 1'b1;
      8'h9f: forever for (int i = 0; i < 3; i++) tx(1, i == 0 ? MK : i == 1 ? TY : CP);
      8'h92, 8'h94: begin
        r = (op == 8'h92) ? 2 : 4;
        rx(r, 24 / r);
        rx(r, 8 / r);
        if (v !== 32'h0000_00ff) disable frame;
        if (op == 8'h94) rx(4, 4);
        forever begin tx(r, MK); tx(r, DV); end
      end
      8'h4b: begin rx(1, 32); for (int i = 0; i < 8; i++) tx(1, UID[63 - 8 * i -: 8]); end
      8'h5a: begin
        rx(1, 32);
        if (v[31:16] !== 16'h0) disable frame;
        p = v[15:8];
        forever begin tx(1, p ^ KEY); p++; end
      end
      8'h44, 8'h42: begin
        rx(1, 24);
        r = v[15:12];
        if (!write_latch_flag || v[23:16] != 0 || v[11:8] != 0 || r < 1 || r > 3) disable frame;
        if (lock[r]) disable frame;
        p = v[7:0];
        if (op == 8'h44) begin pend = 1'b1; @(posedge sck); pend = 1'b0; end
        else forever begin rx(1, 8); mem[r][p] = mem[r][p] & v[7:0]; p++; pend = 1'b1; end
      end
      default: ;
    endcase
  end
  always @(posedge cs_n) begin
    disable frame;
    oe = '0;
    if (pend) begin
      pend = 1'b0;
      write_latch_flag = 1'b0;
      if (op == 8'h44) begin
        busy = 1'b1;
        #(TSE_NS);
        for (int i = 0; i < 256; i++) mem[r][i] = 8'hff;
        busy = 1'b0;
      end
    end
  end
endmodule // flash_dev_model
`default_nettype wire

// ---- sim/flash_host_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_host_asserts #(
  parameter HALF = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // Flash pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  // Select stays low through opcode and one extra half clock
  localparam int WREN_END = 17 * HALF - 1;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Idle check keeps the frame checks from firing on a write to a busy host
  sequence wren_go;
    hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00 ##1
      hwdata[2:0] == 3'h7 && cs_n && $past(cs_n, 8);
  endsequence
  idle_sck_a: assert property (cs_n |-> !sck)
    else $error("serial clock moved while deselected");
  sck_high_a: assert property ($fell(sck) |-> $past(sck, HALF) && !$past(sck, HALF + 1))
    else $error("serial clock high phase wrong");
  sck_low_a: assert property (
    $rose(sck) |-> !$past(sck, HALF) && ($past(sck, HALF + 1) || $past(cs_n, HALF + 1)))
    else $error("serial clock low phase wrong");
  io_hold_a: assert property ($rose(sck) |-> $stable(io_out))
    else $error("data changed at a sampling edge");
  cs_tail_a: assert property ($rose(cs_n) |-> $past(sck, HALF + 1) && !$past(sck, HALF))
    else $error("select did not rise right after last clock");
  wren_start_a: assert property (wren_go |=> !cs_n && !sck && !io_out[0] && io_oe[0])
    else $error("write enable frame did not start");
  wren_len_a: assert property (wren_go |=> !cs_n ##WREN_END !cs_n ##1 cs_n)
    else $error("write enable frame length wrong");
  opc_lane_a: assert property ($fell(cs_n) |-> io_oe[0] [*8])
    else $error("opcode lane not driven");
endmodule // flash_host_asserts
`default_nettype wire

// ---- sim/test_flash_id_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_flash_id_host;
  localparam logic [7:0] MK = 8'h5c; // Arbitrary maker code
  localparam logic [7:0] TY = 8'h31, CP = 8'h17, DV = 8'h2e, KEY = 8'ha5;
  localparam logic [63:0] UID = 64'h0123_4567_89ab_cdef;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, st, r;
  logic [1:0] htrans = '0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, cs_n, sck;
  wire [3:0] io_out, io_oe, io_in;
  int seed, miscompares, n_compared, n_fr, cyc, t, j, k, f, rs;
  int kt[6] = '{0, 1, 2, 3, 4, 4}, nt[6] = '{3, 0, 0, 8, 0, 256};
  int bk[4] = '{4, 5, 6, 6}, bn[4] = '{1, 1, 0, 257};
  logic [23:0] ba[4] = '{24'h000100, 24'h004000, 24'h002000, 24'h001000};
  logic [23:0] a, sa;
  logic [8:0] n;
  logic [7:0] b;
  logic [7:0] dq[$];
  flash_id_host #(.HALF(4)) u_flash_id_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n),
    .sck(sck), .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
  flash_dev_model #(.MK(MK), .TY(TY), .CP(CP), .DV(DV), .KEY(KEY), .UID(UID), .TSE_NS(1600))
    u_dev (.cs_n(cs_n), .sck(sck), .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
  always #4 hclk = ~hclk;
  always @(negedge cs_n) n_fr++;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin miscompares++; final_report; end
  end
  task automatic final_report;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
    output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, ad}; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic run(input int kd, input logic [23:0] ad, input logic [8:0] ln,
    output logic [31:0] s);
    logic [31:0] x;
    bus(1'b1, 8'h04, {8'h0, ad}, x);
    bus(1'b1, 8'h08, {23'h0, ln}, x);
    bus(1'b1, 8'h00, 32'(kd), x);
    do bus(1'b0, 8'h14, '0, s); while (s[0] !== 1'b0);
    bus(1'b1, 8'h14, 32'h6, x);
  endtask
  task automatic prog(input logic [7:0] m, input bit w);
    logic [31:0] x;
    if (w) run(7, 24'h0, 9'h0, x);
    for (int i = 0; i < n; i++) bus(1'b1, 8'h0c, {24'h0, dq[i] & m}, x);
    run(6, sa, n, x);
  endtask
  task automatic erase(input bit w);
    logic [31:0] x;
    if (w) run(7, 24'h0, 9'h0, x);
    run(5, sa, 9'h1, x);
    repeat (250) @(posedge hclk);
  endtask
  task automatic mem_chk(input bit ers);
    for (int i = 0; i < n; i++)
      chk("sec byte", {24'h0, ers ? 8'hff : dq[i]}, {24'h0, u_dev.mem[rs][8'(b + i)]});
  endtask
  function automatic logic [7:0] idb(input int kd, input int i, input logic [7:0] s);
    case (kd)
      0: idb = (i % 3 == 0) ? MK : (i % 3 == 1) ? TY : CP;
      1, 2: idb = (i % 2) ? DV : MK;
      3: idb = UID[63 - 8 * i -: 8];
      default: idb = 8'(s + i) ^ KEY;
    endcase
  endfunction
  // ********************
  // Main sequence
  // ********************
  initial begin
    seed = 79593;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (t = 0; t < 6; t++) begin
      k = kt[t];
      n = nt[t] ? 9'(nt[t]) : 9'(1 + $unsigned($random(seed)) % 8);
      a = (k == 4) ? {16'h0, 8'($random(seed))} : 24'h0;
      run(k, a, n, st);
      chk("status", 32'h2, st & 32'h7);
      for (j = 0; j < n; j++) begin
        bus(1'b0, 8'h10, '0, r);
        chk("id byte", {24'h0, idb(k, j, a[7:0])}, r & 32'hff);
      end
    end
    // Refused orders must not reach the pins
    for (t = 0; t < 4; t++) begin
      f = n_fr;
      run(bk[t], ba[t], 9'(bn[t]), st);
      chk("refused status", 32'h4, st & 32'h7);
      chk("frames", 32'(f), 32'(n_fr));
    end
    rs = 1 + $unsigned($random(seed)) % 3;
    b = 8'($random(seed));
    n = 9'(1 + $unsigned($random(seed)) % 8);
    sa = {8'h00, 4'(rs), 4'h0, b};
    for (j = 0; j < n; j++) dq.push_back(8'($random(seed)));
    prog(8'hff, 1'b1);
    mem_chk(1'b0);
    erase(1'b0);
    mem_chk(1'b0);
    erase(1'b1);
    mem_chk(1'b1);
    prog(8'hff, 1'b0);
    mem_chk(1'b1);
    prog(8'hff, 1'b1);
    u_dev.lock[rs] = 1'b1;
    erase(1'b1);
    mem_chk(1'b0);
    prog(8'h00, 1'b1);
    mem_chk(1'b0);
    final_report;
  end
endmodule // test_flash_id_host
bind flash_id_host flash_host_asserts #(.HALF(HALF)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .cs_n(cs_n), .sck(sck), .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

// ---- src/flash_host_defs.vh ----
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH
// ********************
// Register offsets
// ********************
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_LEN 8'h08
`define REG_WDATA 8'h0c
`define REG_RDATA 8'h10
`define REG_STATUS 8'h14
// ********************
// Status bit positions
// ********************
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_ERR 2
// ********************
// Command kinds
// ********************
`define KIND_JEDEC 3'h0
`define KIND_DUAL_ID 3'h1
`define KIND_QUAD_ID 3'h2
`define KIND_UID 3'h3
`define KIND_SFDP 3'h4
`define KIND_SEC_ERASE 3'h5
`define KIND_SEC_PROG 3'h6
`define KIND_WREN 3'h7
// ********************
// Opcodes and fixed bytes
// ********************
`define OP_JEDEC 8'h9f
`define OP_DUAL_ID 8'h92
`define OP_QUAD_ID 8'h94
`define OP_UID 8'h4b
`define OP_SFDP 8'h5a
`define OP_SEC_ERASE 8'h44
`define OP_SEC_PROG 8'h42
`define OP_WREN 8'h06
`define MODE_BYTE 8'hff
// ********************
// Frame lengths in serial clocks, byte and sector limits
// ********************
`define OPC_CLKS 12'h008
`define UID_DUMMY_CLKS 12'h020
`define SFDP_DUMMY_CLKS 12'h008
`define QUAD_ID_DUMMY_CLKS 12'h004
`define MAX_LEN 9'h100
`define SEC_FIRST 4'h1
`define SEC_LAST 4'h3
// ********************
// Timing
// ********************
`define HCLK_PERIOD_NS 8
`define SCK_PERIOD_NS 64
`define HALF_DIV (`SCK_PERIOD_NS / (2 * `HCLK_PERIOD_NS))
`endif

// ---- src/flash_id_host.v ----
`timescale 1ns/1ps
`include "flash_host_defs.vh"
`default_nettype none
module flash_id_host #(
  parameter HALF = `HALF_DIV
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Flash pins
  output reg cs_n,
  output reg sck,
  output reg [3:0] io_out,
  output reg [3:0] io_oe,
  input wire [3:0] io_in
);

  // ********************
  // Frame phases
  // ********************
  localparam [2:0] PH_IDLE = 3'd0;
  localparam [2:0] PH_OPC = 3'd1;
  localparam [2:0] PH_ADDR = 3'd2;
  localparam [2:0] PH_MODE = 3'd3;
  localparam [2:0] PH_DUMMY = 3'd4;
  localparam [2:0] PH_DATA = 3'd5;
  localparam [2:0] PH_END = 3'd6;
  localparam [2:0] PH_GAP = 3'd7;
  localparam [7:0] HALF_M1 = HALF[7:0] - 8'd1;

  reg [2:0] ph_r;
  reg [2:0] kind_r;
  reg [23:0] addr_r;
  reg [8:0] len_r;
  reg [7:0] wptr_r;
  reg [7:0] rptr_r;
  reg done_r;
  reg err_r;
  reg [7:0] div_r;
  reg [31:0] tx_r;
  reg [7:0] rx_r;
  reg [1:0] lw_r;
  reg [11:0] clks_r;
  reg [3:0] bitpos_r;
  reg [7:0] bidx_r;
  reg [3:0] io_s1_r;
  reg [3:0] io_s2_r;
  reg dp_wr_r;
  reg [7:0] dp_addr_r;
  reg [7:0] buf_mem [0:255];
  reg [7:0] opc;
  reg [7:0] rx_shift;

  // ********************
  // Bus decode
  // ********************
  wire busy = (ph_r != PH_IDLE);
  wire acc = hsel & htrans[1] & hready;
  wire rd_acc = acc & ~hwrite;
  wire cmd_wr = dp_wr_r & (dp_addr_r == `REG_CMD);
  wire stat_wr = dp_wr_r & (dp_addr_r == `REG_STATUS);
  wire wdata_wr = dp_wr_r & (dp_addr_r == `REG_WDATA) & ~busy;
  wire [2:0] new_kind = hwdata[2:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ********************
  // Command checks
  // ********************
  wire sec_kind = (new_kind == `KIND_SEC_ERASE) | (new_kind == `KIND_SEC_PROG);
  wire sec_ok = (addr_r[23:16] == 8'h00) & (addr_r[15:12] >= `SEC_FIRST) &
                (addr_r[15:12] <= `SEC_LAST) & (addr_r[11:8] == 4'h0);
  wire sfdp_ok = (addr_r[23:8] == 16'h0000);
  wire need_len = (new_kind != `KIND_SEC_ERASE) & (new_kind != `KIND_WREN);
  wire len_ok = (len_r != 9'h000) & (len_r <= `MAX_LEN);
  wire cmd_ok = (~need_len | len_ok) & (~sec_kind | sec_ok) &
                ((new_kind != `KIND_SFDP) | sfdp_ok);
  wire start = cmd_wr & ~busy & cmd_ok;
  wire refuse = cmd_wr & (busy | ~cmd_ok);

  always @* begin
    case (new_kind)
      `KIND_JEDEC: opc = `OP_JEDEC;
      `KIND_DUAL_ID: opc = `OP_DUAL_ID;
      `KIND_QUAD_ID: opc = `OP_QUAD_ID;
      `KIND_UID: opc = `OP_UID;
      `KIND_SFDP: opc = `OP_SFDP;
      `KIND_SEC_ERASE: opc = `OP_SEC_ERASE;
      `KIND_SEC_PROG: opc = `OP_SEC_PROG;
      default: opc = `OP_WREN;
    endcase
  end

  // ********************
  // Serial engine helpers
  // ********************
  wire tick = busy & (div_r == HALF_M1);
  wire rise = tick & ~sck & (ph_r != PH_END) & (ph_r != PH_GAP);
  wire fall = tick & sck;
  wire [3:0] wnum = 4'h1 << lw_r;
  wire [3:0] bitpos_nxt = bitpos_r + wnum;
  wire byte_end = (ph_r == PH_DATA) & (bitpos_nxt == 4'h8);
  wire prog = (kind_r == `KIND_SEC_PROG);
  wire store = rise & byte_end & ~prog;
  wire dual = (kind_r == `KIND_DUAL_ID);
  wire quad = (kind_r == `KIND_QUAD_ID);
  wire [11:0] data_clks = {len_r, 3'b000} >> lw_r;
  wire [23:0] addr_eff = (dual | quad) ? 24'h000000 : addr_r;

  always @* begin
    case (lw_r)
      2'd0: rx_shift = {rx_r[6:0], io_s2_r[1]};
      2'd1: rx_shift = {rx_r[5:0], io_s2_r[1:0]};
      default: rx_shift = {rx_r[3:0], io_s2_r};
    endcase
  end

  // Pins change only on falling edges and at frame start or end, so they sit still across each rise
  always @* begin
    io_oe[0] = ~cs_n & ((ph_r == PH_OPC) | (ph_r == PH_ADDR) | (ph_r == PH_MODE) |
               ((ph_r == PH_DUMMY) & (lw_r == 2'd0)) | ((ph_r == PH_DATA) & prog));
    io_oe[1] = io_oe[0] & (lw_r != 2'd0);
    io_oe[3:2] = (lw_r == 2'd2) ? {2{io_oe[0]}} : 2'b11;
    case (lw_r)
      2'd0: io_out = {2'b11, 1'b0, tx_r[31]};
      2'd1: io_out = {2'b11, tx_r[31:30]};
      default: io_out = tx_r[31:28];
    endcase
  end

  // ********************
  // Input synchroniser
  // ********************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  // ********************
  // Register file
  // ********************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
      kind_r <= 3'h0;
      addr_r <= 24'h000000;
      len_r <= 9'h000;
      wptr_r <= 8'h00;
      rptr_r <= 8'h00;
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      dp_wr_r <= acc & hwrite;
      dp_addr_r <= haddr[7:0];
      if (rd_acc) begin
        if (haddr[7:0] == `REG_CMD) begin
          hrdata <= {29'h0, kind_r};
        end else if (haddr[7:0] == `REG_ADDR) begin
          hrdata <= {8'h00, addr_r};
        end else if (haddr[7:0] == `REG_LEN) begin
          hrdata <= {23'h0, len_r};
        end else if (haddr[7:0] == `REG_WDATA) begin
          hrdata <= {24'h0, wptr_r};
        end else if (haddr[7:0] == `REG_RDATA) begin
          hrdata <= {24'h0, buf_mem[rptr_r]};
          rptr_r <= rptr_r + 8'h01;
        end else if (haddr[7:0] == `REG_STATUS) begin
          hrdata <= {29'h0, err_r, done_r, busy};
        end else begin
          hrdata <= 32'h00000000;
        end
      end
      if (dp_wr_r & ~busy & (dp_addr_r == `REG_ADDR)) begin
        addr_r <= hwdata[23:0];
      end
      if (dp_wr_r & ~busy & (dp_addr_r == `REG_LEN)) begin
        len_r <= hwdata[8:0];
      end
      if (wdata_wr) begin
        wptr_r <= wptr_r + 8'h01;
      end
      if (start) begin
        kind_r <= new_kind;
        wptr_r <= 8'h00;
        rptr_r <= 8'h00;
      end
      // Hardware set wins over a software clear in the same cycle
      if (tick & (ph_r == PH_GAP)) begin
        done_r <= 1'b1;
      end else if (stat_wr & hwdata[`STAT_DONE]) begin
        done_r <= 1'b0;
      end
      if (refuse) begin
        err_r <= 1'b1;
      end else if (stat_wr & hwdata[`STAT_ERR]) begin
        err_r <= 1'b0;
      end
    end
  end

  // Byte buffer, shared by program data and read results
  always @(posedge hclk) begin
    if (store) begin
      buf_mem[bidx_r] <= rx_shift;
    end else if (wdata_wr) begin
      buf_mem[wptr_r] <= hwdata[7:0];
    end
  end

  // ********************
  // Serial engine
  // ********************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= PH_IDLE;
      cs_n <= 1'b1;
      sck <= 1'b0;
      div_r <= 8'h00;
      tx_r <= 32'h00000000;
      rx_r <= 8'h00;
      lw_r <= 2'd0;
      clks_r <= 12'h000;
      bitpos_r <= 4'h0;
      bidx_r <= 8'h00;
    end else if (start) begin
      ph_r <= PH_OPC;
      cs_n <= 1'b0;
      sck <= 1'b0;
      div_r <= 8'h00;
      tx_r <= {opc, 24'h000000};
      lw_r <= 2'd0;
      clks_r <= `OPC_CLKS;
      bitpos_r <= 4'h0;
      bidx_r <= 8'h00;
    end else if (busy) begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (tick & (ph_r == PH_END)) begin
        cs_n <= 1'b1;
        ph_r <= PH_GAP;
        lw_r <= 2'd0;
      end else if (tick & (ph_r == PH_GAP)) begin
        ph_r <= PH_IDLE;
      end else if (rise) begin
        sck <= 1'b1;
        clks_r <= clks_r - 12'h001;
        if (ph_r == PH_DATA) begin
          rx_r <= rx_shift;
          bitpos_r <= byte_end ? 4'h0 : bitpos_nxt;
          if (byte_end) begin
            bidx_r <= bidx_r + 8'h01;
          end
        end
      end else if (fall) begin
        sck <= 1'b0;
        if (clks_r != 12'h000) begin
          if ((ph_r == PH_DATA) & prog & (bitpos_r == 4'h0)) begin
            tx_r <= {buf_mem[bidx_r], 24'h000000};
          end else begin
            tx_r <= tx_r << wnum;
          end
        end else begin
          case (ph_r)
            PH_OPC: begin
              if (kind_r == `KIND_WREN) begin
                ph_r <= PH_END;
              end else if (kind_r == `KIND_JEDEC) begin
                ph_r <= PH_DATA;
                clks_r <= data_clks;
              end else if (kind_r == `KIND_UID) begin
                ph_r <= PH_DUMMY;
                tx_r <= 32'h00000000;
                clks_r <= `UID_DUMMY_CLKS;
              end else begin
                ph_r <= PH_ADDR;
                tx_r <= {addr_eff, 8'h00};
                lw_r <= dual ? 2'd1 : (quad ? 2'd2 : 2'd0);
                clks_r <= dual ? 12'd12 : (quad ? 12'd6 : 12'd24);
              end
            end
            PH_ADDR: begin
              if (dual | quad) begin
                ph_r <= PH_MODE;
                tx_r <= {`MODE_BYTE, 24'h000000};
                clks_r <= dual ? 12'd4 : 12'd2;
              end else if (kind_r == `KIND_SFDP) begin
                ph_r <= PH_DUMMY;
                tx_r <= 32'h00000000;
                clks_r <= `SFDP_DUMMY_CLKS;
              end else if (kind_r == `KIND_SEC_ERASE) begin
                ph_r <= PH_END;
              end else begin
                ph_r <= PH_DATA;
                clks_r <= data_clks;
                tx_r <= {buf_mem[8'h00], 24'h000000};
              end
            end
            PH_MODE: begin
              if (quad) begin
                ph_r <= PH_DUMMY;
                clks_r <= `QUAD_ID_DUMMY_CLKS;
              end else begin
                ph_r <= PH_DATA;
                clks_r <= data_clks;
              end
            end
            PH_DUMMY: begin
              ph_r <= PH_DATA;
              clks_r <= data_clks;
            end
            default: begin
              ph_r <= PH_END;
            end
          endcase
        end
      end
    end else begin
      div_r <= 8'h00;
    end
  end

endmodule // flash_id_host
`default_nettype wire
